/* lfcc_pkg.sv */
package lfcc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_RC_CTRL = 8'h00;
	localparam logic [7:0] ADDR_RC_TRIM = 8'h04;
	localparam logic [7:0] ADDR_XO_CTRL = 8'h08;
	localparam logic [7:0] ADDR_MON_CTRL = 8'h0C;
	localparam logic [7:0] ADDR_GATING = 8'h10;
	localparam logic [7:0] ADDR_SELECT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	// field positions and widths
	localparam int LOCK_BIT = 31;
	localparam int RC_EN_BIT = 0;
	localparam int RC_NOLOAD_BIT = 1;
	localparam int TRIM_W = 11;
	localparam int XO_MODE_LSB = 0;
	localparam int XO_MODE_W = 2;
	localparam int XO_XCAP_LSB = 2;
	localparam int XO_ECAP_LSB = 6;
	localparam int CAP_W = 4;
	localparam int XO_COARSE_LSB = 10;
	localparam int XO_FINE_LSB = 12;
	localparam int GAIN_W = 2;
	localparam int XO_CTRL_W = 14;
	localparam int MON_EN_BIT = 0;
	localparam int MON_FT_LSB = 1;
	localparam int MON_DT_LSB = 3;
	localparam int MON_CTRL_W = 5;
	localparam int NUM_GATES = 5;
	localparam int SEL_BIT = 0;
	localparam int ST_STABLE_BIT = 0;
	localparam int ST_XO_USE_BIT = 1;
	localparam int ST_RC_USE_BIT = 2;
	localparam int ST_MISS_BIT = 3;
	localparam int ST_SRC_LSB = 4;
	localparam int ST_STATE_LSB = 6;
	// reset values
	localparam logic [10:0] TRIM_RST = 11'h400;
	// one cap code step is 2 pF, code 0 is 0 pF, code 15 is 30 pF
	localparam int CAP_STEP_PF = 2;
	// missing-clock limit is base plus step times the frequency trim
	localparam logic [4:0] MON_MISS_BASE = 5'h0A;
	localparam logic [4:0] MON_MISS_STEP = 5'h02;
	// clock and monitor rates in Hz
	localparam int CLK_HZ = 50_000_000;
	localparam int MON_FAST_HZ = 1000;
	localparam int MON_SLOW_HZ = 64;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		XO_DISABLE = 2'b00,
		XO_ENABLE = 2'b01,
		XO_BYPASS = 2'b10
	} lfcc_xo_mode_t;
	typedef enum logic [1:0] {
		SRC_NONE = 2'b00,
		SRC_RC = 2'b01,
		SRC_XO = 2'b10
	} lfcc_src_t;
endpackage

/* lfcc_slow_clock_module.sv */
`timescale 1ns/1ns
// What this block does
// - rc control lock blocks writes until por
// - trim lock blocks trim writes until por
// - crystal control lock blocks writes until por
// - monitor control lock blocks writes until por
// - gating lock blocks gating writes until por
// - higher trim code gives lower frequency
// - applied trim code reads back
// - rc clock held off during start-up
// - crystal modes; cap and gain only when enabled
// - factory load copies trim unless disabled
// - monitor enable, frequency and divide trims
// - per-consumer clock gating from bit mask
// - software selects rc or crystal source
// - report driving source: none, rc, crystal
// - load capacitance codes in 2 pF steps
// - miss limit 10, 12, 14 or 16 ticks
// - per-oscillator monitor rate 1 kHz or 64 Hz
// - status: stable, in use flags, missing clock
// - gate bits for five consumer groups
module lfcc_slow_clock_module #(
	parameter int         MON_FAST_CYCLES  = lfcc_pkg::CLK_HZ / lfcc_pkg::MON_FAST_HZ,
	parameter int         MON_SLOW_CYCLES  = lfcc_pkg::CLK_HZ / lfcc_pkg::MON_SLOW_HZ,
	parameter logic [7:0] RC_STARTUP_EDGES = 8'h20,
	parameter logic [7:0] XO_STABLE_EDGES  = 8'h80
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        rc_osc_clk,
	input  wire logic        xo_clk,
	input  wire logic        factory_load,
	input  wire logic [10:0] factory_trim,
	output logic             rc_osc_enable,
	output logic [10:0]      rc_osc_trim,
	output logic [1:0]       xo_mode,
	output logic [3:0]       xo_xtal_cap,
	output logic [3:0]       xo_extal_cap,
	output logic [1:0]       xo_coarse,
	output logic [1:0]       xo_fine,
	output logic [4:0]       clk32k_out
);
	localparam int DIV_W = 20;
	localparam int NG = lfcc_pkg::NUM_GATES;

	//****************************************************************
	// register file and axi4-lite slave
	//****************************************************************
	logic [1:0]                      rc_ctrl, next_rc_ctrl;
	logic [lfcc_pkg::TRIM_W-1:0]     rc_trim, next_rc_trim;
	logic [lfcc_pkg::XO_CTRL_W-1:0]  xo_ctrl, next_xo_ctrl;
	logic [lfcc_pkg::MON_CTRL_W-1:0] mon_ctrl, next_mon_ctrl;
	logic [NG-1:0]                   gate_mask, next_gate_mask;
	logic                            src_sel, next_src_sel;
	logic [4:0]                      lock, next_lock;
	logic                            miss_flag, next_miss_flag;
	logic                            next_bvalid, next_rvalid;
	logic [1:0]                      next_bresp, next_rresp;
	logic [31:0]                     next_rdata;
	logic                            wr_take, miss_set, xo_stable;
	logic [32:0]                     rd_word, ar_word;
	logic [31:0]                     wv;
	lfcc_pkg::lfcc_src_t             cur_src, next_cur_src;

	assign wr_take = awvalid & wvalid & ~bvalid;
	assign awready = wr_take;
	assign wready = wr_take;
	assign arready = ~rvalid;
	assign rc_osc_enable = rc_ctrl[lfcc_pkg::RC_EN_BIT];
	assign rc_osc_trim = rc_trim;

	// bit 32 marks a mapped address
	function automatic logic [32:0] read_reg(input logic [7:0] a);
		logic [32:0] r;
		r = 33'h0_0000_0000;
		r[32] = 1'b1;
		case (a)
			lfcc_pkg::ADDR_RC_CTRL:
			begin
				r[1:0] = rc_ctrl;
				r[lfcc_pkg::LOCK_BIT] = lock[0];
			end
			lfcc_pkg::ADDR_RC_TRIM:
			begin
				r[lfcc_pkg::TRIM_W-1:0] = rc_trim;
				r[lfcc_pkg::LOCK_BIT] = lock[1];
			end
			lfcc_pkg::ADDR_XO_CTRL:
			begin
				r[lfcc_pkg::XO_CTRL_W-1:0] = xo_ctrl;
				r[lfcc_pkg::LOCK_BIT] = lock[2];
			end
			lfcc_pkg::ADDR_MON_CTRL:
			begin
				r[lfcc_pkg::MON_CTRL_W-1:0] = mon_ctrl;
				r[lfcc_pkg::LOCK_BIT] = lock[3];
			end
			lfcc_pkg::ADDR_GATING:
			begin
				r[NG-1:0] = gate_mask;
				r[lfcc_pkg::LOCK_BIT] = lock[4];
			end
			lfcc_pkg::ADDR_SELECT: r[lfcc_pkg::SEL_BIT] = src_sel;
			lfcc_pkg::ADDR_STATUS:
			begin
				r[lfcc_pkg::ST_STABLE_BIT] = xo_stable;
				r[lfcc_pkg::ST_XO_USE_BIT] = (cur_src == lfcc_pkg::SRC_XO);
				r[lfcc_pkg::ST_RC_USE_BIT] = (cur_src == lfcc_pkg::SRC_RC);
				r[lfcc_pkg::ST_MISS_BIT] = miss_flag;
				r[lfcc_pkg::ST_SRC_LSB +: 2] = cur_src;
				r[lfcc_pkg::ST_STATE_LSB +: 2] = {
					xo_ctrl[lfcc_pkg::XO_MODE_LSB +: lfcc_pkg::XO_MODE_W]
						!= lfcc_pkg::XO_DISABLE,
					rc_ctrl[lfcc_pkg::RC_EN_BIT]};
			end
			default: r[32] = 1'b0;
		endcase
		return r;
	endfunction

	always_comb
	begin
		next_rc_ctrl = rc_ctrl;
		next_rc_trim = rc_trim;
		next_xo_ctrl = xo_ctrl;
		next_mon_ctrl = mon_ctrl;
		next_gate_mask = gate_mask;
		next_src_sel = src_sel;
		next_lock = lock;
		next_bvalid = bvalid & ~bready;
		next_bresp = bresp;
		next_rvalid = rvalid & ~rready;
		next_rresp = rresp;
		next_rdata = rdata;
		rd_word = read_reg(awaddr);
		ar_word = read_reg(araddr);
		wv = rd_word[31:0];
		for (int b = 0; b < 4; b++)
		begin
			if (wstrb[b])
				wv[b*8 +: 8] = wdata[b*8 +: 8];
		end
		// a locked register ignores the write but still answers okay
		if (wr_take)
		begin
			next_bvalid = 1'b1;
			next_bresp = rd_word[32] ? lfcc_pkg::RESP_OKAY : lfcc_pkg::RESP_SLVERR;
			case (awaddr)
				lfcc_pkg::ADDR_RC_CTRL:
				if (!lock[0])
				begin
					next_rc_ctrl = wv[1:0];
					next_lock[0] = wv[lfcc_pkg::LOCK_BIT];
				end
				lfcc_pkg::ADDR_RC_TRIM:
				if (!lock[1])
				begin
					next_rc_trim = wv[lfcc_pkg::TRIM_W-1:0];
					next_lock[1] = wv[lfcc_pkg::LOCK_BIT];
				end
				lfcc_pkg::ADDR_XO_CTRL:
				if (!lock[2])
				begin
					next_xo_ctrl = wv[lfcc_pkg::XO_CTRL_W-1:0];
					next_lock[2] = wv[lfcc_pkg::LOCK_BIT];
				end
				lfcc_pkg::ADDR_MON_CTRL:
				if (!lock[3])
				begin
					next_mon_ctrl = wv[lfcc_pkg::MON_CTRL_W-1:0];
					next_lock[3] = wv[lfcc_pkg::LOCK_BIT];
				end
				lfcc_pkg::ADDR_GATING:
				if (!lock[4])
				begin
					next_gate_mask = wv[NG-1:0];
					next_lock[4] = wv[lfcc_pkg::LOCK_BIT];
				end
				lfcc_pkg::ADDR_SELECT: next_src_sel = wv[lfcc_pkg::SEL_BIT];
				default: next_src_sel = src_sel;
			endcase
		end
		// factory data wins over a software trim write in the same cycle
		if (factory_load && !rc_ctrl[lfcc_pkg::RC_NOLOAD_BIT])
			next_rc_trim = factory_trim;
		// a new miss wins over a write-one clear
		next_miss_flag = miss_flag;
		if (wr_take && awaddr == lfcc_pkg::ADDR_STATUS && wstrb[0]
			&& wdata[lfcc_pkg::ST_MISS_BIT])
			next_miss_flag = 1'b0;
		if (miss_set)
			next_miss_flag = 1'b1;
		if (arvalid && !rvalid)
		begin
			next_rvalid = 1'b1;
			next_rdata = ar_word[31:0];
			next_rresp = ar_word[32] ? lfcc_pkg::RESP_OKAY : lfcc_pkg::RESP_SLVERR;
		end
	end

	// locks clear only with rst_n, which stands for power-on reset
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rc_ctrl <= 2'h0;
			rc_trim <= lfcc_pkg::TRIM_RST;
			xo_ctrl <= 14'h0000;
			mon_ctrl <= 5'h00;
			gate_mask <= 5'h00;
			src_sel <= 1'b0;
			lock <= 5'h00;
			miss_flag <= 1'b0;
			bvalid <= 1'b0;
			bresp <= lfcc_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= lfcc_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			rc_ctrl <= next_rc_ctrl;
			rc_trim <= next_rc_trim;
			xo_ctrl <= next_xo_ctrl;
			mon_ctrl <= next_mon_ctrl;
			gate_mask <= next_gate_mask;
			src_sel <= next_src_sel;
			lock <= next_lock;
			miss_flag <= next_miss_flag;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	//****************************************************************
	// oscillator control, source switch, gating, monitor
	//****************************************************************
	logic                rc_q, xo_q, next_rc_q, next_xo_q;
	logic [7:0]          rc_cnt, xo_cnt, next_rc_cnt, next_xo_cnt;
	logic [NG-1:0]       gate_q, next_gate_q, next_clk32k_out;
	logic [DIV_W-1:0]    div_cnt, next_div_cnt;
	logic [4:0]          miss_cnt, next_miss_cnt, miss_limit;
	logic [1:0]          next_xo_mode, next_coarse, next_fine;
	logic [3:0]          next_xcap, next_ecap;
	logic                rc_rise, xo_rise, rc_ready, xo_run, cur_lvl, want_lvl;
	logic                mon_on, slow, tick, cur_edge;
	lfcc_pkg::lfcc_src_t want_src;

	assign rc_ready = (rc_cnt == RC_STARTUP_EDGES);
	assign xo_stable = (xo_cnt == XO_STABLE_EDGES);

	// gates change only while the source level is low, so no pulse is cut
	generate
		for (genvar g = 0; g < NG; g++)
		begin : gate_ch
			assign next_gate_q[g] = cur_lvl ? gate_q[g] : gate_mask[g];
			assign next_clk32k_out[g] = cur_lvl & gate_q[g];
		end
	endgenerate

	always_comb
	begin
		next_rc_q = rc_osc_clk;
		next_xo_q = xo_clk;
		rc_rise = rc_osc_clk & ~rc_q;
		xo_rise = xo_clk & ~xo_q;
		next_xo_mode = xo_ctrl[lfcc_pkg::XO_MODE_LSB +: lfcc_pkg::XO_MODE_W];
		xo_run = (next_xo_mode == lfcc_pkg::XO_ENABLE) || (next_xo_mode == lfcc_pkg::XO_BYPASS);
		next_xcap = 4'h0;
		next_ecap = 4'h0;
		next_coarse = 2'h0;
		next_fine = 2'h0;
		if (next_xo_mode == lfcc_pkg::XO_ENABLE)
		begin
			next_xcap = xo_ctrl[lfcc_pkg::XO_XCAP_LSB +: lfcc_pkg::CAP_W];
			next_ecap = xo_ctrl[lfcc_pkg::XO_ECAP_LSB +: lfcc_pkg::CAP_W];
			next_coarse = xo_ctrl[lfcc_pkg::XO_COARSE_LSB +: lfcc_pkg::GAIN_W];
			next_fine = xo_ctrl[lfcc_pkg::XO_FINE_LSB +: lfcc_pkg::GAIN_W];
		end
		next_rc_cnt = rc_cnt;
		if (!rc_ctrl[lfcc_pkg::RC_EN_BIT])
			next_rc_cnt = 8'h00;
		else if (rc_rise && !rc_ready)
			next_rc_cnt = rc_cnt + 8'h01;
		next_xo_cnt = xo_cnt;
		if (!xo_run)
			next_xo_cnt = 8'h00;
		else if (xo_rise && !xo_stable)
			next_xo_cnt = xo_cnt + 8'h01;
		case (cur_src)
			lfcc_pkg::SRC_RC: cur_lvl = rc_q;
			lfcc_pkg::SRC_XO: cur_lvl = xo_q;
			default: cur_lvl = 1'b0;
		endcase
		// rc is offered only after start-up, so its output stays off until then
		if (src_sel)
			want_src = xo_stable ? lfcc_pkg::SRC_XO : lfcc_pkg::SRC_NONE;
		else
			want_src = rc_ready ? lfcc_pkg::SRC_RC : lfcc_pkg::SRC_NONE;
		case (want_src)
			lfcc_pkg::SRC_RC: want_lvl = rc_q;
			lfcc_pkg::SRC_XO: want_lvl = xo_q;
			default: want_lvl = 1'b0;
		endcase
		next_cur_src = cur_src;
		if (want_src != cur_src && !cur_lvl && !want_lvl)
			next_cur_src = want_src;
		// monitor rate per oscillator: control bit 3 for rc, bit 4 for crystal
		mon_on = mon_ctrl[lfcc_pkg::MON_EN_BIT] && (cur_src != lfcc_pkg::SRC_NONE);
		slow = (cur_src == lfcc_pkg::SRC_XO) ? mon_ctrl[lfcc_pkg::MON_DT_LSB + 1]
			: mon_ctrl[lfcc_pkg::MON_DT_LSB];
		tick = 1'b0;
		next_div_cnt = div_cnt + 20'h0_0001;
		if (!mon_on)
			next_div_cnt = 20'h0_0000;
		else if (div_cnt == (slow ? DIV_W'(MON_SLOW_CYCLES - 1) : DIV_W'(MON_FAST_CYCLES - 1)))
		begin
			next_div_cnt = 20'h0_0000;
			tick = 1'b1;
		end
		miss_limit = lfcc_pkg::MON_MISS_BASE
			+ 5'(lfcc_pkg::MON_MISS_STEP * mon_ctrl[lfcc_pkg::MON_FT_LSB +: 2]);
		cur_edge = (cur_src == lfcc_pkg::SRC_RC) ? rc_rise : xo_rise;
		next_miss_cnt = miss_cnt;
		if (!mon_on || cur_edge)
			next_miss_cnt = 5'h00;
		else if (tick && miss_cnt < miss_limit)
			next_miss_cnt = miss_cnt + 5'h01;
		miss_set = mon_on && (miss_cnt >= miss_limit);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rc_q <= 1'b0;
			xo_q <= 1'b0;
			rc_cnt <= 8'h00;
			xo_cnt <= 8'h00;
			cur_src <= lfcc_pkg::SRC_NONE;
			gate_q <= 5'h00;
			clk32k_out <= 5'h00;
			div_cnt <= 20'h0_0000;
			miss_cnt <= 5'h00;
			xo_mode <= 2'h0;
			xo_xtal_cap <= 4'h0;
			xo_extal_cap <= 4'h0;
			xo_coarse <= 2'h0;
			xo_fine <= 2'h0;
		end
		else
		begin
			rc_q <= next_rc_q;
			xo_q <= next_xo_q;
			rc_cnt <= next_rc_cnt;
			xo_cnt <= next_xo_cnt;
			cur_src <= next_cur_src;
			gate_q <= next_gate_q;
			clk32k_out <= next_clk32k_out;
			div_cnt <= next_div_cnt;
			miss_cnt <= next_miss_cnt;
			xo_mode <= next_xo_mode;
			xo_xtal_cap <= next_xcap;
			xo_extal_cap <= next_ecap;
			xo_coarse <= next_coarse;
			xo_fine <= next_fine;
		end
	end
endmodule

/* lfcc_slow_clock_assertions.sv */
`timescale 1ns/1ns
// ****
// bus handshake and clock output checks
// ****
module lfcc_slow_clock_assertions (
	input	wire logic			clk,
	input	wire logic			rst_n,
	input	wire logic			awvalid,
	input	wire logic			wvalid,
	input	wire logic			bvalid,
	input	wire logic			bready,
	input	wire logic [1:0]	bresp,
	input	wire logic			arvalid,
	input	wire logic			rvalid,
	input	wire logic			rready,
	input	wire logic [31:0]	rdata,
	input	wire logic			factory_load,
	input	wire logic			rc_osc_enable,
	input	wire logic [10:0]	rc_osc_trim,
	input	wire logic [1:0]	xo_mode,
	input	wire logic [3:0]	xo_xtal_cap,
	input	wire logic [3:0]	xo_extal_cap,
	input	wire logic [1:0]	xo_coarse,
	input	wire logic [1:0]	xo_fine,
	input	wire logic [4:0]	clk32k_out
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// a pulse on consumer clock 0 is never cut short by a switch or a gate change
	sequence s_high4;
		clk32k_out[0] [*4];
	endsequence
	a_write_answer: assert property (awvalid && wvalid && !bvalid |=> bvalid)
		else $error("write not answered");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_cap_gated: assert property (xo_mode != lfcc_pkg::XO_ENABLE |->
		{xo_xtal_cap, xo_extal_cap, xo_coarse, xo_fine} == 12'h000)
		else $error("crystal settings leak outside enable mode");
	a_rc_startup: assert property ($rose(rc_osc_enable) && xo_mode == 2'h0 |->
		(clk32k_out == 5'h00) [*8])
		else $error("clock out during start-up");
	a_trim_cause: assert property ($changed(rc_osc_trim) |->
		$past(awvalid && wvalid && !bvalid) || $past(factory_load) || $past(factory_load, 2))
		else $error("trim moved without cause");
	a_pulse_whole: assert property ($rose(clk32k_out[0]) |-> s_high4)
		else $error("short clock pulse");
endmodule

/* lfcc_osc_model.sv */
`timescale 1ns/1ns
// ****
// both oscillators; each stops only at a low level
// ****
module lfcc_osc_model #(
	parameter int	RC_HALF	= 4,
	parameter int	XO_HALF	= 5
) (
	input	wire logic			clk,
	input	wire logic			rc_enable,
	input	wire logic [1:0]	xo_mode,
	input	wire logic			stall,
	output	logic				rc_clk,
	output	logic				xo_clk
);
	int		rc_cnt = 0;
	int		xo_cnt = 0;
	logic	rc_lvl = 1'b0;
	logic	xo_lvl = 1'b0;
	assign rc_clk = rc_lvl;
	assign xo_clk = xo_lvl;
	always @(posedge clk)
	begin
		rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
		xo_cnt <= (xo_cnt == XO_HALF - 1) ? 0 : xo_cnt + 1;
		if (rc_cnt == RC_HALF - 1)
			rc_lvl <= rc_lvl ? 1'b0 : rc_enable;
		// stall models a dead crystal for the monitor
		if (xo_cnt == XO_HALF - 1)
			xo_lvl <= xo_lvl ? 1'b0 : (xo_mode != 2'h0 && !stall);
	end
endmodule

/* tb.sv */
`timescale 1ns/1ns
module tb;
	logic clk, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, rc_osc_clk, xo_clk, rc_osc_enable;
	logic [1:0] bresp, rresp, xo_mode, xo_coarse, xo_fine;
	logic factory_load = 0, stall = 0;
	logic [10:0] factory_trim = 0, rc_osc_trim;
	logic [3:0] xo_xtal_cap, xo_extal_cap;
	logic [4:0] clk32k_out;
	int n_fail = 0, n_checks = 0;
	lfcc_slow_clock_module #(.MON_FAST_CYCLES(20), .MON_SLOW_CYCLES(40),
		.RC_STARTUP_EDGES(8'h04), .XO_STABLE_EDGES(8'h08)) dut (.*);
	lfcc_osc_model u_osc (.clk(clk), .rc_enable(rc_osc_enable), .xo_mode(xo_mode),
		.stall(stall), .rc_clk(rc_osc_clk), .xo_clk(xo_clk));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		@(negedge clk);
		while (!awready) @(negedge clk);
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		@(negedge clk);
		while (!bvalid) @(negedge clk);
		chk("write resp", {30'h0, bresp}, {30'h0, lfcc_pkg::RESP_OKAY});
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		@(negedge clk);
		while (!arready) @(negedge clk);
		@(posedge clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		@(negedge clk);
		while (!rvalid) @(negedge clk);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("register", d & m, e);
		chk("read resp", {30'h0, r}, {30'h0, lfcc_pkg::RESP_OKAY});
	endtask
	// bounded poll; the watchdog still guards a stuck bus
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		for (int i = 0; i < 200 && (d & m) !== e; i++) rd(a, d, r);
		chk("status poll", d & m, e);
	endtask
	task automatic fload(input logic [10:0] v);
		factory_trim <= v;
		factory_load <= 1'b1;
		@(posedge clk);
		factory_load <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rdc(lfcc_pkg::ADDR_RC_TRIM, 32'hFFFF_FFFF, 32'h0000_0400);
		rdc(lfcc_pkg::ADDR_STATUS, 32'h0000_00FF, 32'h0000_0000);
		rd(8'h1C, d, r);
		chk("unmapped resp", {30'h0, r}, {30'h0, lfcc_pkg::RESP_SLVERR});
		chk("unmapped data", d, 32'h0000_0000);
	endtask
	task automatic t_rc();
		logic [4:0] seen;
		wr(lfcc_pkg::ADDR_RC_CTRL, 32'h0000_0001);
		rdc(lfcc_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
		wr(lfcc_pkg::ADDR_GATING, 32'h0000_0000);
		wr(lfcc_pkg::ADDR_SELECT, 32'h0000_0000);
		poll(lfcc_pkg::ADDR_STATUS, 32'h0000_0034, 32'h0000_0014);
		wr(lfcc_pkg::ADDR_GATING, 32'h0000_0015);
		seen = 5'h00;
		repeat (60) @(posedge clk) seen |= clk32k_out;
		chk("gated outputs", {27'h0, seen}, 32'h0000_0015);
	endtask
	task automatic t_trim();
		wr(lfcc_pkg::ADDR_RC_CTRL, 32'h0000_0000);
		chk("rc enable", {31'h0, rc_osc_enable}, 32'h0000_0000);
		wr(lfcc_pkg::ADDR_RC_TRIM, 32'h0000_07FF);
		rdc(lfcc_pkg::ADDR_RC_TRIM, 32'h0000_07FF, 32'h0000_07FF);
		chk("trim out", {21'h0, rc_osc_trim}, 32'h0000_07FF);
		fload(11'h123);
		rdc(lfcc_pkg::ADDR_RC_TRIM, 32'h0000_07FF, 32'h0000_0123);
		wr(lfcc_pkg::ADDR_RC_CTRL, 32'h0000_0002);
		fload(11'h055);
		rdc(lfcc_pkg::ADDR_RC_TRIM, 32'h0000_07FF, 32'h0000_0123);
		wr(lfcc_pkg::ADDR_RC_CTRL, 32'h0000_0001);
	endtask
	task automatic t_xo();
		wr(lfcc_pkg::ADDR_XO_CTRL, 32'h0000_1E3D);
		repeat (2) @(posedge clk);
		chk("caps", {20'h0, xo_fine, xo_coarse, xo_extal_cap, xo_xtal_cap}, 32'h0000_078F);
		poll(lfcc_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(lfcc_pkg::ADDR_GATING, 32'h0000_0000);
		wr(lfcc_pkg::ADDR_SELECT, 32'h0000_0001);
		poll(lfcc_pkg::ADDR_STATUS, 32'h0000_0036, 32'h0000_0022);
		wr(lfcc_pkg::ADDR_GATING, 32'h0000_001F);
		wr(lfcc_pkg::ADDR_XO_CTRL, 32'h0000_1E3E);
		repeat (2) @(posedge clk);
		chk("bypass caps", {20'h0, xo_fine, xo_coarse, xo_extal_cap, xo_xtal_cap}, 32'h0);
		chk("bypass mode", {30'h0, xo_mode}, 32'h0000_0002);
	endtask
	task automatic mon_case(input logic [31:0] ctrl, input int quiet);
		wr(lfcc_pkg::ADDR_MON_CTRL, ctrl);
		stall <= 1'b1;
		repeat (quiet) @(posedge clk);
		rdc(lfcc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0000);
		poll(lfcc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
		stall <= 1'b0;
		repeat (20) @(posedge clk);
		wr(lfcc_pkg::ADDR_STATUS, 32'h0000_0008);
		rdc(lfcc_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0000);
	endtask
	task automatic t_mon();
		// fast rate with limit 10, then crystal at the slow rate with limit 16:
		// 400 quiet cycles would already trip a fast or a short limit
		mon_case(32'h0000_0001, 150);
		mon_case(32'h0000_0017, 400);
	endtask
	task automatic t_locks();
		logic [7:0] adr [5] = '{lfcc_pkg::ADDR_RC_CTRL, lfcc_pkg::ADDR_RC_TRIM,
			lfcc_pkg::ADDR_XO_CTRL, lfcc_pkg::ADDR_MON_CTRL, lfcc_pkg::ADDR_GATING};
		logic [31:0] v;
		logic [1:0] r;
		foreach (adr[i])
		begin
			rd(adr[i], v, r);
			wr(adr[i], v | 32'h8000_0000);
			wr(adr[i], 32'h0000_0000);
			rdc(adr[i], 32'hFFFF_FFFF, v | 32'h8000_0000);
		end
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wr(lfcc_pkg::ADDR_RC_CTRL, 32'h0000_0001);
		rdc(lfcc_pkg::ADDR_RC_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_rc();
		t_trim();
		t_xo();
		t_mon();
		t_locks();
		complete_run();
	end
	initial
	begin
		#1_000_000;
		n_fail++;
		complete_run();
	end
endmodule
bind lfcc_slow_clock_module lfcc_slow_clock_assertions u_chk (.clk(clk), .rst_n(rst_n),
	.awvalid(awvalid), .wvalid(wvalid), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.factory_load(factory_load), .rc_osc_enable(rc_osc_enable), .rc_osc_trim(rc_osc_trim),
	.xo_mode(xo_mode), .xo_xtal_cap(xo_xtal_cap), .xo_extal_cap(xo_extal_cap),
	.xo_coarse(xo_coarse), .xo_fine(xo_fine), .clk32k_out(clk32k_out));
